// >>> spi_status_flags.v
// Purpose: spi word engine with transmit buffer, bit-error, desync
//          and parity status flags behind an apb slave
// Assumes: 10 MHz clk_sys; link clock sampled as an ordinary pin
// Notes:   msb first, data out on falling, sampled on rising sclk
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "spi_flags_consts.vh"
// How it works
// (R1) write while shifting sets buffer-full flag
// (R2) buffer-full clears when word enters shifter
// (R3) write into empty path leaves flag clear
// (R4) buffer-full is read only, one means busy
// (R5) own transmit line checked at receive point
// (R6) reading receive data clears three error flags
// (R7) desync judged only in master mode
// (R8) early or late ready release sets desync
// (R9) desync with enable raises interrupt
// (R10) desync judged after word completes, may lag
// (R11) parity bit appended after last data bit
// (R12) received parity mismatch sets parity flag
// (R13) receive data right justified, low sixteen
// (R14) slave holds ready through word, releases promptly; slave mode here drives no ready line
// (R15) all flags zero after reset
module spi_status_flags #(
    parameter HALF_CYC  = `SCLK_HALF_CYC,   // sclk half period in clk_sys cycles
    parameter REL_CYC   = `REL_DELAY_CYC,   // ready release allowance in cycles
    parameter FIFO_DEPTH = 4
) (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        sclkIn,
    output reg         sclkOut,
    output reg         sclkOe,
    input  wire        masterOutIn,
    output reg         masterOutOut,
    output reg         masterOutOe,
    input  wire        slaveOutIn,
    output reg         slaveOutOut,
    output reg         slaveOutOe,
    input  wire        slaveReadyN,
    output reg         desyncIrq
);
    // control register
    reg  [31:0] ctrlReg;
    wire        isMaster = ctrlReg[`CTRL_MASTER];
    wire        parEn    = ctrlReg[`CTRL_PAR_EN];
    wire        parOdd   = ctrlReg[`CTRL_PAR_ODD];
    wire [4:0]  charLen  = {1'b0, ctrlReg[`CTRL_LEN_HI:`CTRL_LEN_LO]} + 5'd1;
    wire [4:0]  nBits    = charLen + {4'd0, parEn};

    // synchronised pins: {ready_n, slave out, master out, sclk}
    wire [3:0]  pinSync;
    reg         sclkPrevReg;                 // edge detect on the second stage
    sync_two #(.WIDTH(4)) pinSyncer (
        .clk  (clk_sys),
        .ce   (ce),
        .din  ({slaveReadyN, slaveOutIn, masterOutIn, sclkIn}),
        .dout (pinSync)
    );
    wire        sclkS    = pinSync[0];
    wire        readyNS  = pinSync[3];
    wire        ownLineS = isMaster ? pinSync[1] : pinSync[2];
    wire        rxLineS  = isMaster ? pinSync[2] : pinSync[1];

    // transmit path state
    reg  [15:0] holdReg;                     // holding buffer word
    reg         holdFullReg;                 // buffer-full flag
    reg  [15:0] txWordReg;                   // word in the shifter
    reg         busyReg;                     // shifter holds a word
    reg  [4:0]  bitCntReg;                   // bits already sent
    reg  [15:0] rxShiftReg;                  // receive shifter
    reg         curBitReg;                   // bit now on the line
    reg  [7:0]  divCntReg;                   // master sclk divider
    reg         sclkReg;                     // master sclk level

    // status flags
    reg         bitErrReg;
    reg         desyncReg;
    reg         parErrReg;
    reg         earlyRelReg;                 // ready seen released mid word
    reg         relWaitReg;                  // watching ready release
    reg  [15:0] relCntReg;                   // release allowance counter

    // apb decode
    wire        setup    = psel & ~penable;
    wire        access   = psel & penable & pready;
    wire        wrTx     = access & pwrite &
                           ((paddr == `OFS_TX_WORD) | (paddr == `OFS_TX_FORMAT));
    wire        rdRx     = access & ~pwrite & (paddr == `OFS_RX_STATUS);
    wire        mapped   = (paddr == `OFS_CTRL) | (paddr == `OFS_TX_WORD) |
                           (paddr == `OFS_TX_FORMAT) | (paddr == `OFS_RX_STATUS);

    // receive fifo between shifter and status register
    wire        fifoInReady;
    wire        fifoOutValid;
    wire [15:0] fifoOutData;
    reg         pushReg;
    reg  [15:0] pushDataReg;
    word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(2)) rxFifo (
        .clk      (clk_sys),
        .rst      (rst),
        .ce       (ce),
        .inValid  (pushReg),
        .inReady  (fifoInReady),
        .inData   (pushDataReg),
        .outValid (fifoOutValid),
        .outReady (rdRx),
        .outData  (fifoOutData)
    );

    // edges of whichever clock drives the word
    wire        masterTick = (divCntReg == HALF_CYC[7:0] - 8'd1);
    wire        riseEv = isMaster ? (busyReg & masterTick & ~sclkReg)
                                  : (sclkS & ~sclkPrevReg);
    wire        fallEv = isMaster ? (busyReg & masterTick & sclkReg)
                                  : (~sclkS & sclkPrevReg);
    wire        lastBit  = (bitCntReg == nBits - 5'd1);

    // parity of a right-justified word, masked to the character length
    function parityOf;
        input [15:0] w;
        input [4:0]  len;
        input        odd;
        reg   [15:0] m;
        begin
            m = 16'hffff >> (5'd16 - len);
            parityOf = (^(w & m)) ^ odd;
        end
    endfunction

    // bit to drive for a given count: data msb first, then parity
    function bitFor;
        input [15:0] w;
        input [4:0]  cnt;
        input [4:0]  len;
        input        odd;
        reg   [4:0]  idx;
        begin
            idx = len - 5'd1 - cnt;
            if (cnt < len) begin
                bitFor = w[idx[3:0]];
            end else begin
                bitFor = parityOf(w, len, odd); // (R11)
            end
        end
    endfunction

    // a word finishes at the falling edge after its last receive point
    wire        wordDone = busyReg & fallEv & lastBit;
    // master waits for room in the fifo before shifting a buffered word
    wire        canStart = ~isMaster | fifoInReady;

    // set terms for the flags
    wire        bitErrSet = busyReg & riseEv & (ownLineS != curBitReg); // (R5)
    wire        parErrSet = busyReg & riseEv & parEn & (bitCntReg == charLen) &
                            (parityOf(rxShiftReg, charLen, parOdd) != rxLineS); // (R12)
    wire        relLate   = relWaitReg & (relCntReg == 16'd0) & ~readyNS;
    // late only while the slave still holds its ready line low
    wire        desyncSet = isMaster & (relLate | (relWaitReg & earlyRelReg)); // (R7) (R8)

    // apb slave: answer in the access phase one cycle after setup
    always @(posedge clk_sys) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            if (setup && !pwrite) begin
                case (paddr)
                    `OFS_CTRL:      prdata <= ctrlReg;
                    `OFS_TX_WORD:   prdata <= {16'h0000, holdReg};
                    `OFS_TX_FORMAT: prdata <= {16'h0000, holdReg};
                    `OFS_RX_STATUS: prdata <= {2'b00, holdFullReg, bitErrReg, desyncReg,
                                               parErrReg, 10'h000,
                                               fifoOutValid ? fifoOutData : 16'h0000}; // (R13) (R4)
                    default:        prdata <= 32'h00000000;
                endcase
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // control register write; the status register ignores writes
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrlReg <= `CTRL_RESET;
        end else if (ce && access && pwrite && paddr == `OFS_CTRL) begin
            ctrlReg <= {24'h000000, pwdata[7:0]};
        end
    end

    // transmit buffer and shifter
    always @(posedge clk_sys) begin
        if (rst) begin
            holdReg     <= 16'h0000;
            holdFullReg <= 1'b0;
            txWordReg   <= 16'h0000;
            busyReg     <= 1'b0;
            bitCntReg   <= 5'd0;
            curBitReg   <= 1'b0;
            rxShiftReg  <= 16'h0000;
            pushReg     <= 1'b0;
            pushDataReg <= 16'h0000;
        end else if (ce) begin
            pushReg <= 1'b0;
            // receive point: shift in data bits only
            if (busyReg && riseEv && bitCntReg < charLen) begin
                rxShiftReg <= {rxShiftReg[14:0], rxLineS}; // (R13)
            end
            // transmit point: next bit or end of word
            if (busyReg && fallEv) begin
                if (lastBit) begin
                    busyReg     <= 1'b0;
                    bitCntReg   <= 5'd0;
                    pushReg     <= 1'b1;
                    pushDataReg <= rxShiftReg & (16'hffff >> (5'd16 - charLen));
                end else begin
                    bitCntReg <= bitCntReg + 5'd1;
                    curBitReg <= bitFor(txWordReg, bitCntReg + 5'd1, charLen, parOdd);
                end
            end
            if (wrTx && (busyReg || holdFullReg)) begin
                // shifter or buffer occupied: park the word, flag full
                holdReg     <= pwdata[15:0];
                holdFullReg <= 1'b1; // (R1)
            end else if (wrTx) begin
                // path empty: straight into the shifter, flag stays clear
                txWordReg   <= pwdata[15:0]; // (R3)
                curBitReg   <= bitFor(pwdata[15:0], 5'd0, charLen, parOdd);
                busyReg     <= 1'b1;
                rxShiftReg  <= 16'h0000;
            end else if (holdFullReg && !busyReg && canStart) begin
                // buffered word moves on, flag clears in the same edge
                txWordReg   <= holdReg;
                curBitReg   <= bitFor(holdReg, 5'd0, charLen, parOdd);
                busyReg     <= 1'b1;
                holdFullReg <= 1'b0; // (R2)
                rxShiftReg  <= 16'h0000;
            end
        end
    end

    // master sclk divider, idles low outside a word
    always @(posedge clk_sys) begin
        if (rst) begin
            divCntReg <= 8'd0;
            sclkReg   <= 1'b0;
        end else if (ce) begin
            if (!isMaster || !busyReg) begin
                divCntReg <= 8'd0;
                sclkReg   <= 1'b0;
            end else if (masterTick) begin
                divCntReg <= 8'd0;
                sclkReg   <= ~sclkReg;
            end else begin
                divCntReg <= divCntReg + 8'd1;
            end
        end
    end

    // slave-ready watch: early release during word, late release after it
    always @(posedge clk_sys) begin
        if (rst) begin
            earlyRelReg <= 1'b0;
            relWaitReg  <= 1'b0;
            relCntReg   <= 16'd0;
        end else if (ce) begin
            if (!isMaster) begin
                earlyRelReg <= 1'b0; // (R7)
                relWaitReg  <= 1'b0;
            end else if (busyReg && riseEv && readyNS) begin
                earlyRelReg <= 1'b1; // (R8)
            end
            // judged only once the word is complete, so may lag a word
            if (isMaster && wordDone) begin
                relWaitReg <= 1'b1; // (R10)
                relCntReg  <= REL_CYC[15:0];
            end else if (relWaitReg) begin
                if (earlyRelReg || readyNS || relCntReg == 16'd0) begin
                    relWaitReg  <= 1'b0;
                    earlyRelReg <= 1'b0;
                end else begin
                    relCntReg <= relCntReg - 16'd1;
                end
            end
        end
    end

    // status flags: set wins over the clearing read
    always @(posedge clk_sys) begin
        if (rst) begin
            bitErrReg <= 1'b0; // (R15)
            desyncReg <= 1'b0;
            parErrReg <= 1'b0;
        end else if (ce) begin
            bitErrReg <= (bitErrReg & ~rdRx) | bitErrSet; // (R6)
            desyncReg <= (desyncReg & ~rdRx) | desyncSet; // (R6)
            parErrReg <= (parErrReg & ~rdRx) | parErrSet; // (R6)
        end
    end

    // pin drivers and interrupt, all registered
    always @(posedge clk_sys) begin
        if (rst) begin
            sclkPrevReg  <= 1'b0;
            sclkOut      <= 1'b0;
            sclkOe       <= 1'b0;
            masterOutOut <= 1'b0;
            masterOutOe  <= 1'b0;
            slaveOutOut  <= 1'b0;
            slaveOutOe   <= 1'b0;
            desyncIrq    <= 1'b0;
        end else if (ce) begin
            sclkPrevReg  <= sclkS;
            sclkOut      <= sclkReg;
            sclkOe       <= isMaster;
            masterOutOut <= curBitReg;
            masterOutOe  <= isMaster;
            slaveOutOut  <= curBitReg;
            slaveOutOe   <= ~isMaster & busyReg;
            // level while the flag stands and the enable is set
            desyncIrq    <= ctrlReg[`CTRL_DESYNC_IE] &
                            ((desyncReg & ~rdRx) | desyncSet); // (R9)
        end
    end

    // limitation: a write into an idle shifter starts at once even with a
    // full receive fifo; only words parked in the holding buffer wait for room
endmodule
`default_nettype wire

// >>> spi_flags_consts.vh
// Purpose: shared constants of the spi status-flag block
// Assumes: 10 MHz system clock, apb word registers
// Notes:   definitions only
`ifndef SPI_FLAGS_CONSTS_VH
`define SPI_FLAGS_CONSTS_VH

// register byte addresses
`define OFS_CTRL        8'h00
`define OFS_TX_WORD     8'h04
`define OFS_TX_FORMAT   8'h08
`define OFS_RX_STATUS   8'h0c

// control register fields
`define CTRL_MASTER     0
`define CTRL_PAR_EN     1
`define CTRL_PAR_ODD    2
`define CTRL_DESYNC_IE  3
`define CTRL_LEN_LO     4
`define CTRL_LEN_HI     7
`define CTRL_RESET      32'h000000f0

// receive status register fields
`define RX_TX_BUFFER_FULL_FLAG       29
`define RX_BIT_MISMATCH_FLAG       28
`define RX_DESYNC       27
`define RX_PARITY_MISMATCH_FLAG       26
`define RX_DATA_W       16

// timing
`define CLK_MHZ         10
`define REL_DELAY_NS    500
`define REL_DELAY_CYC   (((`REL_DELAY_NS * `CLK_MHZ) / 1000) < 1 ? 1 : \
                         ((`REL_DELAY_NS * `CLK_MHZ) / 1000))
`define SCLK_HALF_CYC   4

`endif

// >>> sync_two.v
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   only the second stage leaves this module
`timescale 1ns/1ps
`default_nettype none
module sync_two #(
    parameter WIDTH = 4
) (
    input  wire             clk,
    input  wire             ce,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] stage1Reg;   // metastable stage, read by dout only

    // two flip-flops; no reset, so pin values keep passing through under reset
    always @(posedge clk) begin
        if (ce) begin
            stage1Reg <= din;
            dout      <= stage1Reg;
        end
    end
endmodule
`default_nettype wire

// >>> word_fifo.v
// Purpose: small fifo holding received data words only
// Assumes: one clock, synchronous reset
// Notes:   head word is a combinational memory read, full and empty honest
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             ce,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] memReg [0:DEPTH-1];  // storage
    reg [AW-1:0]    wrPtrReg;            // write pointer
    reg [AW-1:0]    rdPtrReg;            // read pointer
    reg [AW:0]      countReg;            // words held
    wire            doPush;
    wire            doPop;

    assign inReady  = (countReg != DEPTH[AW:0]);
    assign outValid = (countReg != {(AW+1){1'b0}});
    assign outData  = memReg[rdPtrReg];
    assign doPush   = inValid & inReady;
    assign doPop    = outValid & outReady;

    // storage write, no reset needed on data
    always @(posedge clk) begin
        if (ce && doPush) begin
            memReg[wrPtrReg] <= inData;
        end
    end

    // pointers and count
    always @(posedge clk) begin
        if (rst) begin
            wrPtrReg <= {AW{1'b0}};
            rdPtrReg <= {AW{1'b0}};
            countReg <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (doPush) begin
                wrPtrReg <= (wrPtrReg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtrReg + 1'b1;
            end
            if (doPop) begin
                rdPtrReg <= (rdPtrReg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtrReg + 1'b1;
            end
            if (doPush && !doPop) begin
                countReg <= countReg + 1'b1;
            end else if (doPop && !doPush) begin
                countReg <= countReg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> spi_buffer_status_flags_monitor.sv
// Purpose: port-level assertions for the spi status-flag block
// Assumes: ce held high by the bench
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module spi_buffer_status_flags_monitor (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sclkOut,
    input wire logic        sclkOe,
    input wire logic        masterOutOe,
    input wire logic        slaveOutOe,
    input wire logic        desyncIrq
);
    // all checks live in the one system clock domain
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("answer held too long");
    a_data_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_err_unmapped: assert property (psel && !penable && paddr >= 8'h10 |=> pslverr && pready)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (psel && !penable && paddr < 8'h10 |=> !pslverr)
        else $error("mapped access refused");
    a_reset_quiet: assert property ($fell(rst) |-> !desyncIrq && prdata == 32'h0)
        else $error("state left over from reset");
    a_sclk_half: assert property ($rose(sclkOut) |-> sclkOut [*4])
        else $error("serial clock high phase short");
    a_irq_master: assert property (desyncIrq |-> sclkOe)
        else $error("desync outside master mode");
    a_out_split: assert property (slaveOutOe |-> !masterOutOe)
        else $error("both transmit lines driven");
endmodule
bind spi_status_flags spi_buffer_status_flags_monitor spi_status_flags_monitor_inst (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclkOut(sclkOut),
    .sclkOe(sclkOe), .masterOutOe(masterOutOe), .slaveOutOe(slaveOutOe),
    .desyncIrq(desyncIrq));
`default_nettype wire

// >>> spi_slave_model.sv
// Purpose: remote spi slave with a ready line, answering one word per arm
// Assumes: master drives data on falling and samples on rising sclk
// Notes:   mode 0 prompt release, 1 early release, 2 late release
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
    input  wire logic        clk_sys,
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        arm,
    input  wire logic [16:0] word,
    input  wire logic [4:0]  nBits,
    input  wire logic [1:0]  mode,
    output logic             slaveOut,
    output logic             readyN,
    output logic [16:0]      captured
);
    logic       sclkQ;    // last sclk sample, to find edges
    logic [1:0] phase;    // 0 wait, 1 in word, 2 word done
    logic       idleOut;  // level shown while no bit is due
    int         cnt;      // rising edges seen in this word
    int         hold;     // cycles since word end
    int         idx;      // bit position now on the line
    initial begin
        readyN = 1'b1;
        captured = 17'h0;
        sclkQ = 1'b0;
        phase = 2'd0;
        idleOut = 1'b0;
        cnt = 0;
    end
    // the next bit follows the falling sclk at once, as a real slave does;
    // waiting for a system clock edge would miss the master's next sample
    assign idx = cnt - int'(sclk & sclkQ);
    assign slaveOut = (phase == 2'd1 && idx < int'(nBits)) ? word[int'(nBits) - 1 - idx]
                                                           : idleOut;
    // one word per arm: re-arming waits for the bench, so no stray restart
    always @(posedge clk_sys) begin
        sclkQ <= sclk;
        if (!arm) begin
            phase <= 2'd0;
            readyN <= 1'b1;
            idleOut <= ~slaveOut;  // released line never shows stale data
        end else if (phase == 2'd0) begin
            phase <= 2'd1;
            cnt <= 0;
            readyN <= 1'b0;
        end else if (phase == 2'd1) begin
            if (sclk && !sclkQ) begin
                captured <= {captured[15:0], mosi};
                cnt <= cnt + 1;
                if (mode == 2'd1 && cnt == int'(nBits) - 2) begin
                    readyN <= 1'b1;  // faulty slave: gone before last sample
                end
            end else if (!sclk && sclkQ && cnt == int'(nBits)) begin
                phase <= 2'd2;
                hold <= 0;
            end
        end else begin
            hold <= hold + 1;
            if (hold >= (mode == 2'd2 ? 20 : 0)) begin
                readyN <= 1'b1;
            end
            if (readyN) begin
                idleOut <= ~slaveOut;
            end
        end
    end
endmodule
`default_nettype wire

// >>> spi_buffer_status_flags_test.sv
// Purpose: self-checking bench for the spi status-flag block
// Assumes: master mode only, partner slave on the serial side
// Notes:   reads queue their expectation, a watcher compares on pready
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch %0t got %h expected %h", $time, (got), (exp)); end end
module spi_buffer_status_flags_test;
    typedef struct { logic [31:0] d; logic [31:0] m; logic e; } note_t;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, td;
    logic        corrupt = 0, arm = 0;  // loopback fault, partner arm
    logic [16:0] word = 17'h0;
    logic [4:0]  nBits = 5'd8;
    logic [1:0]  mode = 2'd0;
    logic [7:0]  sw;                    // slave data byte
    wire  [31:0] prdata;
    wire         pready, pslverr, sclkOut, sclkOe, moOut, moOe, soOut, soOe;
    wire         slaveOut, readyN, desyncIrq;
    wire  [16:0] captured;
    wire         sclkWire = sclkOe & sclkOut;   // idle low when undriven
    wire         moWire = moOut ^ corrupt;      // fault injection on loopback
    note_t       notes[$], got;
    int          fails = 0, n_compared = 0, cycles = 0, seed = 6;
    spi_status_flags spi_status_flags_inst (
        .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclkIn(sclkWire), .sclkOut(sclkOut),
        .sclkOe(sclkOe), .masterOutIn(moWire), .masterOutOut(moOut),
        .masterOutOe(moOe), .slaveOutIn(slaveOut), .slaveOutOut(soOut),
        .slaveOutOe(soOe), .slaveReadyN(readyN), .desyncIrq(desyncIrq));
    spi_slave_model spi_slave_model_inst (
        .clk_sys(clk_sys), .sclk(sclkWire), .mosi(moWire), .arm(arm), .word(word),
        .nBits(nBits), .mode(mode), .slaveOut(slaveOut), .readyN(readyN),
        .captured(captured));
    initial forever #50 clk_sys = ~clk_sys;
    // one apb transfer; expectation queued before the request goes out
    task apb(input logic w, input logic [7:0] a, input logic [31:0] dat,
             input logic [31:0] ex, input logic [31:0] m, input logic er);
        notes.push_back('{ex, m, er});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task arm_partner;
        arm <= 1'b0;
        @(posedge clk_sys);
        arm <= 1'b1;
        @(posedge clk_sys);
    endtask
    task final_report;
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // watcher: every answer takes the oldest note
    always @(posedge clk_sys) begin
        if (pready === 1'b1) begin
            got = notes.pop_front();
            `CHECK(prdata & got.m, got.d)
            `CHECK(pslverr, got.e)
        end
    end
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            final_report;
        end
    end
    initial begin
        idle(20);
        rst <= 1'b0;
        idle(1);
        apb(0, 8'h00, 0, 32'h000000f0, 32'hffffffff, 0);
        apb(0, 8'h0c, 0, 32'h0, 32'hffffffff, 0);
        apb(1, 8'h0c, 32'hffffffff, 0, 0, 0);
        apb(0, 8'h0c, 0, 32'h0, 32'hffffffff, 0);
        apb(0, 8'h10, 0, 0, 0, 1);
        sw = 8'($random(seed));
        word <= {9'h0, sw};
        arm_partner;
        apb(1, 8'h00, 32'h71, 0, 0, 0);
        apb(1, 8'h04, $random(seed), 0, 0, 0);
        apb(0, 8'h0c, 0, 32'h0, 32'h20000000, 0);
        apb(1, 8'h08, $random(seed), 0, 0, 0);
        apb(0, 8'h0c, 0, 32'h20000000, 32'h20000000, 0);
        idle(80);
        apb(0, 8'h0c, 0, {24'h0, sw}, 32'h3400ffff, 0);
        idle(100);
        apb(0, 8'h0c, 0, 32'h0, 32'h20000000, 0);
        for (int i = 0; i < 4; i++) begin
            arm_partner;
            apb(1, 8'h04, $random(seed), 0, 0, 0);
            idle(80);
        end
        for (int i = 0; i < 5; i++) apb(0, 8'h0c, 0, i < 4 ? {24'h0, sw} : 0, 32'hffff, 0);
        corrupt <= 1'b1;
        arm_partner;
        apb(1, 8'h04, $random(seed), 0, 0, 0);
        idle(80);
        corrupt <= 1'b0;
        apb(0, 8'h0c, 0, {24'h100000, sw}, 32'h1400ffff, 0);
        apb(0, 8'h0c, 0, 32'h0, 32'h14000000, 0);
        word <= {8'h0, sw, ^sw};  // even parity bit, wrong for odd mode
        nBits <= 5'd9;
        arm_partner;
        apb(1, 8'h00, 32'h77, 0, 0, 0);
        td = $random(seed);
        apb(1, 8'h04, td, 0, 0, 0);
        idle(90);
        apb(0, 8'h0c, 0, {24'h040000, sw}, 32'h3c00ffff, 0);
        `CHECK(captured[8:0], {td[7:0], ~^td[7:0]})
        apb(0, 8'h0c, 0, 32'h0, 32'h3c000000, 0);
        word <= {9'h0, sw};
        nBits <= 5'd8;
        apb(1, 8'h00, 32'h79, 0, 0, 0);
        for (int k = 1; k < 3; k++) begin
            mode <= 2'(k);
            arm_partner;
            apb(1, 8'h04, $random(seed), 0, 0, 0);
            idle(110);
            `CHECK(desyncIrq, 1'b1)
            apb(0, 8'h0c, 0, 32'h08000000, 32'h08000000, 0);
            idle(2);
            `CHECK(desyncIrq, 1'b0)
        end
        final_report;
    end
endmodule
`default_nettype wire
